// ===== src/ssp_regs.svh
// Purpose: Shared constants of the serial memory target port.
// Assumes: Included by bare name from the package and the design modules.
// Notes:   Definitions only.
`ifndef SSP_REGS_SVH
`define SSP_REGS_SVH

// ==========================================================================
// Instruction codes
`define SSP_CMD_READ          8'h03
`define SSP_CMD_WRITE         8'h02
`define SSP_STATUS_READ_CMD   8'h05
`define SSP_STATUS_WRITE_CMD  8'h01

// ==========================================================================
// Widths and sizes
`define SSP_DATA_W            8
`define SSP_ADDR_W            13
`define SSP_MEM_WORDS         8192
`define SSP_PAGE_BITS         5
`define SSP_FIFO_DEPTH        32
`define SSP_LAST_CMD_BIT      4'h7
`define SSP_LAST_ADDR_BIT     4'hF

// ==========================================================================
// Status register layout and reset value
`define SSP_MODE_HI           7
`define SSP_MODE_LO           6
`define SSP_STATUS_MASK       8'hC1
`define SSP_STATUS_ONE        8'h02
`define SSP_STATUS_RST        8'h02

`endif

// ===== src/ssp_pkg.sv
// Purpose: Types shared by the serial memory target port modules.
// Assumes: Constants come from ssp_regs.svh.
// Notes:   Nothing here is imported; users write ssp_pkg::name.
`include "ssp_regs.svh"

package ssp_pkg;

  // ========================================================================
  // Sequence states
  typedef enum logic [2:0] {
    SSP_IDLE   = 3'b000,
    SSP_CMD    = 3'b001,
    SSP_ADDR   = 3'b010,
    SSP_RDATA  = 3'b011,
    SSP_WDATA  = 3'b100,
    SSP_SRRD   = 3'b101,
    SSP_SRWR   = 3'b110,
    SSP_IGNORE = 3'b111
  } ssp_state_e;

  // ========================================================================
  // Address sequencing modes held in the top status bits
  typedef enum logic [1:0] {
    SSP_MODE_BYTE  = 2'b00,
    SSP_MODE_BURST = 2'b01,
    SSP_MODE_PAGE  = 2'b10,
    SSP_MODE_RSVD  = 2'b11
  } ssp_mode_e;

  // ========================================================================
  // Carriers
  typedef struct packed {
    logic cs_n;
    logic sck;
    logic si;
    logic hold_n;
  } ssp_pins_s;

  typedef struct packed {
    logic [`SSP_ADDR_W-1:0] addr;
    logic [`SSP_DATA_W-1:0] data;
  } ssp_wr_s;

endpackage

// ===== src/ssp_fifo.sv
// Purpose: Synchronous FIFO between the serial write path and the array.
// Assumes: One clock; DEPTH is a power of two.
// Notes:   Full and empty come from pointers with one extra wrap bit.
`include "ssp_regs.svh"
module ssp_fifo #(
  parameter int W     = 21,
  parameter int DEPTH = `SSP_FIFO_DEPTH
) (
  input  wire logic         i_mclk,
  input  wire logic         i_rst,
  input  wire logic         i_in_valid,
  output logic              o_in_ready,
  input  wire logic [W-1:0] i_in_data,
  output logic              o_out_valid,
  input  wire logic         i_out_ready,
  output logic [W-1:0]      o_out_data,
  output logic              o_empty
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem_r [DEPTH];
  logic [AW:0]  wp_r;
  logic [AW:0]  rp_r;
  logic         full;
  logic         push;
  logic         pop;

  assign full        = (wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]);
  assign o_empty     = (wp_r == rp_r);
  assign o_in_ready  = ~full;
  assign o_out_valid = ~o_empty;
  assign o_out_data  = mem_r[rp_r[AW-1:0]];
  assign push        = i_in_valid & ~full;
  assign pop         = i_out_ready & ~o_empty;

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      wp_r <= '0;
      rp_r <= '0;
    end else begin
      if (push) begin
        wp_r <= wp_r + 1'b1;
      end
      if (pop) begin
        rp_r <= rp_r + 1'b1;
      end
    end
  end

  // The storage holds no reset so it can map onto plain RAM.
  always_ff @(posedge i_mclk) begin
    if (push) begin
      mem_r[wp_r[AW-1:0]] <= i_in_data;
    end
  end
endmodule

// ===== src/ssp_target.sv
// Purpose: Serial command port of an 8K x 8 static memory, SPI target side.
// Assumes: Pins are asynchronous to i_mclk; SCK runs well below i_mclk / 4.
// Notes:   All pins pass a two-stage synchroniser; SCK edges are found by
//          comparing the synchronised level with its previous value.
`include "ssp_regs.svh"

module ssp_target (
  input  wire logic i_mclk,
  input  wire logic i_rst,
  input  wire logic i_cs_n,
  input  wire logic i_sck,
  input  wire logic i_si,
  input  wire logic i_hold_n,
  output logic      o_so,
  output logic      o_so_oe,
  output logic      o_standby
);
  localparam int WR_W = `SSP_ADDR_W + `SSP_DATA_W;

  // ========================================================================
  // Pin synchroniser and edge detection
  ssp_pkg::ssp_pins_s meta_r;
  ssp_pkg::ssp_pins_s sync_r;
  logic               sck_prev_r;
  logic               cs_prev_r;

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      meta_r     <= '{cs_n: 1'b1, sck: 1'b0, si: 1'b0, hold_n: 1'b1};
      sync_r     <= '{cs_n: 1'b1, sck: 1'b0, si: 1'b0, hold_n: 1'b1};
      sck_prev_r <= 1'b0;
      cs_prev_r  <= 1'b1;
    end else begin
      meta_r     <= '{cs_n: i_cs_n, sck: i_sck, si: i_si, hold_n: i_hold_n};
      sync_r     <= meta_r;
      sck_prev_r <= sync_r.sck;
      cs_prev_r  <= sync_r.cs_n;
    end
  end

  logic sck_rise_raw;
  logic sck_fall_raw;
  logic cs_start;
  logic selected;
  logic paused_r;
  logic sck_rise;
  logic sck_fall;

  assign selected     = ~sync_r.cs_n;
  assign sck_rise_raw = sync_r.sck & ~sck_prev_r;
  assign sck_fall_raw = ~sync_r.sck & sck_prev_r;
  assign cs_start     = selected & cs_prev_r;
  // A fall that arrives with the pause low is the edge on which a pause
  // requested with the clock high takes hold, so it is not acted on.
  assign sck_rise     = sck_rise_raw & selected & sync_r.hold_n & ~paused_r;
  assign sck_fall     = sck_fall_raw & selected & sync_r.hold_n & ~paused_r;

  // ========================================================================
  // Address sequencing
  function automatic logic [`SSP_ADDR_W-1:0] next_addr(
    input logic [`SSP_ADDR_W-1:0] a,
    input logic [1:0]             mode
  );
    logic [`SSP_ADDR_W-1:0] n;
    n = a;
    unique case (ssp_pkg::ssp_mode_e'(mode))
      ssp_pkg::SSP_MODE_PAGE: begin
        n[`SSP_PAGE_BITS-1:0] = a[`SSP_PAGE_BITS-1:0] + 5'h01;
      end
      ssp_pkg::SSP_MODE_BURST: begin
        n = a + 13'h0001;
      end
      ssp_pkg::SSP_MODE_BYTE, ssp_pkg::SSP_MODE_RSVD: begin
        n = a;
      end
    endcase
    return n;
  endfunction

  // ========================================================================
  // Sequence state
  ssp_pkg::ssp_state_e     state_r,     state_nxt;
  logic [3:0]              cnt_r,       cnt_nxt;
  logic [14:0]             shift_r,     shift_nxt;
  logic [`SSP_ADDR_W-1:0]  addr_r,      addr_nxt;
  logic [7:0]              status_r,    status_nxt;
  logic [7:0]              tx_r,        tx_nxt;
  logic                    so_r,        so_nxt;
  logic                    oe_r,        oe_nxt;
  logic                    drive_r,     drive_nxt;
  logic                    paused_nxt;
  logic                    is_wr_r,     is_wr_nxt;
  logic                    fetch_r,     fetch_nxt;
  logic                    load_r;
  logic                    pend_r,      pend_nxt;
  ssp_pkg::ssp_wr_s        pend_data_r, pend_data_nxt;
  logic                    standby_r,   standby_nxt;
  logic [`SSP_DATA_W-1:0]  rd_q_r;
  logic [15:0]             word_in;
  logic                    fifo_in_ready;
  logic                    fifo_out_valid;
  logic                    fifo_empty;
  logic [WR_W-1:0]         fifo_out_data;
  ssp_pkg::ssp_wr_s        drain;

  assign word_in = {shift_r, sync_r.si};
  assign drain   = ssp_pkg::ssp_wr_s'(fifo_out_data);

  always_comb begin
    state_nxt     = state_r;
    cnt_nxt       = cnt_r;
    shift_nxt     = shift_r;
    addr_nxt      = addr_r;
    status_nxt    = status_r;
    tx_nxt        = tx_r;
    so_nxt        = so_r;
    drive_nxt     = drive_r;
    is_wr_nxt     = is_wr_r;
    fetch_nxt     = 1'b0;
    pend_nxt      = pend_r & ~fifo_in_ready;
    pend_data_nxt = pend_data_r;
    paused_nxt    = paused_r;

    if (load_r) begin
      tx_nxt = rd_q_r;
    end

    // Pause bookkeeping leaves every other sequence register untouched.
    if (!selected) begin
      paused_nxt = 1'b0;
    end else if (!sync_r.hold_n && (!sync_r.sck || sck_fall_raw)) begin
      paused_nxt = 1'b1;
    end else if (sync_r.hold_n && !sync_r.sck) begin
      paused_nxt = 1'b0;
    end

    if (!selected) begin
      state_nxt = ssp_pkg::SSP_IDLE;
      cnt_nxt   = 4'h0;
      drive_nxt = 1'b0;
    end else if (cs_start) begin
      state_nxt = ssp_pkg::SSP_CMD;
      cnt_nxt   = 4'h0;
      drive_nxt = 1'b0;
    end else if (sck_rise) begin
      shift_nxt = word_in[14:0];
      cnt_nxt   = cnt_r + 4'h1;
      unique case (state_r)
        ssp_pkg::SSP_CMD: begin
          if (cnt_r == `SSP_LAST_CMD_BIT) begin
            cnt_nxt = 4'h0;
            unique case (word_in[7:0])
              `SSP_CMD_READ: begin
                state_nxt = ssp_pkg::SSP_ADDR;
                is_wr_nxt = 1'b0;
              end
              `SSP_CMD_WRITE: begin
                state_nxt = ssp_pkg::SSP_ADDR;
                is_wr_nxt = 1'b1;
              end
              `SSP_STATUS_READ_CMD: begin
                state_nxt = ssp_pkg::SSP_SRRD;
                tx_nxt    = status_r;
              end
              `SSP_STATUS_WRITE_CMD: begin
                state_nxt = ssp_pkg::SSP_SRWR;
              end
              default: begin
                state_nxt = ssp_pkg::SSP_IGNORE;
              end
            endcase
          end
        end
        ssp_pkg::SSP_ADDR: begin
          if (cnt_r == `SSP_LAST_ADDR_BIT) begin
            cnt_nxt   = 4'h0;
            addr_nxt  = word_in[`SSP_ADDR_W-1:0];
            state_nxt = is_wr_r ? ssp_pkg::SSP_WDATA : ssp_pkg::SSP_RDATA;
            fetch_nxt = ~is_wr_r;
          end
        end
        ssp_pkg::SSP_WDATA: begin
          if (cnt_r == `SSP_LAST_CMD_BIT) begin
            // A byte that finds the holding slot still occupied is lost;
            // with a 32-deep FIFO draining at i_mclk this cannot happen.
            cnt_nxt = 4'h0;
            if (!pend_nxt) begin
              pend_nxt      = 1'b1;
              pend_data_nxt = '{addr: addr_r, data: word_in[7:0]};
            end
            addr_nxt = next_addr(addr_r, status_r[`SSP_MODE_HI:`SSP_MODE_LO]);
          end
        end
        ssp_pkg::SSP_SRWR: begin
          if (cnt_r == `SSP_LAST_CMD_BIT) begin
            cnt_nxt    = 4'h0;
            status_nxt = (word_in[7:0] & `SSP_STATUS_MASK) | `SSP_STATUS_ONE;
            state_nxt  = ssp_pkg::SSP_IGNORE;
          end
        end
        default: begin
          cnt_nxt = cnt_r;
        end
      endcase
    end else if (sck_fall && (state_r == ssp_pkg::SSP_RDATA ||
                              state_r == ssp_pkg::SSP_SRRD)) begin
      so_nxt    = tx_r[3'h7 - cnt_r[2:0]];
      drive_nxt = 1'b1;
      cnt_nxt   = cnt_r + 4'h1;
      if (cnt_r == `SSP_LAST_CMD_BIT) begin
        cnt_nxt = 4'h0;
        if (state_r == ssp_pkg::SSP_RDATA) begin
          addr_nxt  = next_addr(addr_r, status_r[`SSP_MODE_HI:`SSP_MODE_LO]);
          fetch_nxt = 1'b1;
        end
      end
    end

    oe_nxt = drive_nxt & selected & sync_r.hold_n & ~paused_nxt;
    standby_nxt = sync_r.cs_n & ~pend_r & fifo_empty;
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      state_r     <= ssp_pkg::SSP_IDLE;
      cnt_r       <= 4'h0;
      shift_r     <= 15'h0000;
      addr_r      <= 13'h0000;
      status_r    <= `SSP_STATUS_RST;
      tx_r        <= 8'h00;
      so_r        <= 1'b0;
      oe_r        <= 1'b0;
      drive_r     <= 1'b0;
      paused_r    <= 1'b0;
      is_wr_r     <= 1'b0;
      fetch_r     <= 1'b0;
      load_r      <= 1'b0;
      pend_r      <= 1'b0;
      pend_data_r <= '0;
      standby_r   <= 1'b1;
    end else begin
      state_r     <= state_nxt;
      cnt_r       <= cnt_nxt;
      shift_r     <= shift_nxt;
      addr_r      <= addr_nxt;
      status_r    <= status_nxt;
      tx_r        <= tx_nxt;
      so_r        <= so_nxt;
      oe_r        <= oe_nxt;
      drive_r     <= drive_nxt;
      paused_r    <= paused_nxt;
      is_wr_r     <= is_wr_nxt;
      fetch_r     <= fetch_nxt;
      load_r      <= fetch_r;
      pend_r      <= pend_nxt;
      pend_data_r <= pend_data_nxt;
      standby_r   <= standby_nxt;
    end
  end

  assign o_so      = so_r;
  assign o_so_oe   = oe_r;
  assign o_standby = standby_r;

  // ========================================================================
  // Write buffer and memory array
  ssp_fifo #(
    .W     (WR_W),
    .DEPTH (`SSP_FIFO_DEPTH)
  ) u_wr_fifo (
    .i_mclk      (i_mclk),
    .i_rst       (i_rst),
    .i_in_valid  (pend_r),
    .o_in_ready  (fifo_in_ready),
    .i_in_data   (pend_data_r),
    .o_out_valid (fifo_out_valid),
    .i_out_ready (~fetch_r),
    .o_out_data  (fifo_out_data),
    .o_empty     (fifo_empty)
  );

  logic [`SSP_DATA_W-1:0] mem_r [`SSP_MEM_WORDS];

  // Reads take the single array port first; the FIFO absorbs the stall.
  always_ff @(posedge i_mclk) begin
    if (fetch_r) begin
      rd_q_r <= mem_r[addr_r];
    end else if (fifo_out_valid) begin
      mem_r[drain.addr] <= drain.data;
    end
  end
endmodule

// ===== test/ssp_target_sva.sv
// Purpose: Pin-level checks of the serial memory target port.
// Assumes: Pins change away from i_mclk edges; SCK half period is 4 mclk.
// Notes:   Delays allow for the two-stage pin synchronisers.
module ssp_target_sva (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_cs_n,
  input wire logic i_sck,
  input wire logic i_si,
  input wire logic i_hold_n,
  input wire logic o_so,
  input wire logic o_so_oe,
  input wire logic o_standby
);
  timeunit 1ns;
  timeprecision 100ps;

  // ==========================================================
  // Properties
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (i_rst);

  // A deselect that lasts long enough for the write buffer to drain.
  sequence s_deselect;
    $rose(i_cs_n) ##1 i_cs_n [*8];
  endsequence

  sequence s_paused;
    !i_hold_n [*6];
  endsequence

  AST_DESEL_FLOAT: assert property (i_cs_n [*5] |-> !o_so_oe)
    else $error("output driven while deselected");
  AST_PAUSE_FLOAT: assert property (!i_hold_n [*5] |-> !o_so_oe)
    else $error("output driven while paused");
  AST_SEL_ACTIVE: assert property (!i_cs_n [*6] |-> !o_standby)
    else $error("standby while selected");
  AST_SO_AFTER_FALL: assert property ($changed(o_so) && o_so_oe |-> !$past(i_sck, 2))
    else $error("output changed without a falling clock");
  AST_OE_RISE: assert property ($rose(o_so_oe) |-> !$past(i_sck, 2) && !$past(i_cs_n, 4))
    else $error("output enabled at a wrong moment");
  AST_OE_NEEDS_SEL: assert property (o_so_oe |-> !$past(i_cs_n, 4))
    else $error("output enabled without select");
  AST_STANDBY_BOUND: assert property (s_deselect |-> ##[0:100] (o_standby || !i_cs_n))
    else $error("standby not reached");
  AST_STANDBY_DESEL: assert property ($rose(o_standby) |-> $past(i_cs_n, 3))
    else $error("standby entered while selected");
  AST_PAUSE_HOLD: assert property (s_paused |-> $stable(o_so))
    else $error("output moved while paused");
endmodule

bind ssp_target ssp_target_sva chk_u (
  .i_mclk(i_mclk), .i_rst(i_rst), .i_cs_n(i_cs_n), .i_sck(i_sck), .i_si(i_si),
  .i_hold_n(i_hold_n), .o_so(o_so), .o_so_oe(o_so_oe), .o_standby(o_standby)
);

// ===== test/ssp_host_model.sv
// Purpose: SPI host that drives the target port pins, mode 0.
// Assumes: Tasks are called shortly after an mclk rising edge.
// Notes:   SO is taken late in the high phase, well after it settles.
module ssp_host_model (
  input  wire logic i_so,
  input  wire logic i_so_oe,
  output logic      o_cs_n,
  output logic      o_sck,
  output logic      o_si,
  output logic      o_hold_n
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    o_cs_n = 1'b1;
    o_sck = 1'b0;
    o_si = 1'b0;
    o_hold_n = 1'b1;
  end

  // ==========================================================
  // Frame and bit tasks
  task automatic frame_start();
    o_cs_n = 1'b0;
    #100;
  endtask

  // SI is flipped when a frame ends so that no stale bit lingers.
  task automatic frame_end();
    o_cs_n = 1'b1;
    o_si = ~o_si;
    #100;
  endtask

  task automatic xbit(input logic b, output logic r);
    o_si = b;
    #100 o_sck = 1'b1;
    #99 r = i_so_oe ? i_so : 1'bx;
    #1 o_sck = 1'b0;
  endtask

  task automatic xbyte(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      xbit(tx[i], rx[i]);
    end
  endtask

  // Clock and data keep moving while paused; the target must ignore them.
  // The pause is lowered half a period after the last fall, so that fall
  // still shifts its bit out before the sequence freezes.
  task automatic pause_on();
    #100;
    o_hold_n = 1'b0;
    repeat (2) begin
      #100 o_sck = 1'b1;
      o_si = ~o_si;
      #100 o_sck = 1'b0;
    end
  endtask

  task automatic pause_off();
    o_hold_n = 1'b1;
    #100;
  endtask
endmodule

// ===== test/serial_sram_spi_target_port_tb_top.sv
// Purpose: Self-checking bench of the serial memory target port.
// Assumes: 40 MHz mclk, 200 ns serial clock from the host model.
// Notes:   Row loop covers modes and wrap; pause and bad codes follow.
`include "ssp_regs.svh"
module serial_sram_spi_target_port_tb_top;
  timeunit 1ns;
  timeprecision 100ps;

  typedef struct packed {
    logic [7:0]  sts;
    logic [15:0] addr;
    logic [7:0]  d0;
    logic [7:0]  d1;
  } ssp_row_s;

  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic cs_n, sck, si, hold_n, so, so_oe, standby;
  int   fails = 0;
  int   total_checks = 0;
  int   cycles = 0;
  int   oe_hits = 0;
  ssp_row_s rows [4] = '{'{8'h00, 16'h0005, 8'hA5, 8'h3C}, '{8'h41, 16'h1FFF, 8'h5A, 8'hC3},
                         '{8'h80, 16'h003F, 8'h96, 8'h69}, '{8'hFF, 16'hE123, 8'h0F, 8'hF0}};

  ssp_target dut_u (.i_mclk(mclk), .i_rst(rst), .i_cs_n(cs_n), .i_sck(sck), .i_si(si),
    .i_hold_n(hold_n), .o_so(so), .o_so_oe(so_oe), .o_standby(standby));
  ssp_host_model host_u (.i_so(so), .i_so_oe(so_oe), .o_cs_n(cs_n), .o_sck(sck),
    .o_si(si), .o_hold_n(hold_n));

  initial begin
    forever #12.5 mclk = ~mclk;
  end

  // ==========================================================
  // Watchdog and helpers
  always @(posedge mclk) begin
    cycles++;
    if (so_oe === 1'b1) oe_hits++;
    if (cycles == 20000) begin
      fails++;
      report_and_stop();
    end
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  function automatic logic [12:0] next_addr(input logic [1:0] m, input logic [12:0] a);
    if (m == 2'b01) return a + 13'h0001;
    if (m == 2'b10) return {a[12:5], a[4:0] + 5'h01};
    return a;
  endfunction

  task automatic access(input logic [7:0] op, input logic [15:0] a, input logic [7:0] w0,
                        input logic [7:0] w1, output logic [7:0] r0, output logic [7:0] r1);
    logic [7:0] junk;
    host_u.frame_start();
    host_u.xbyte(op, junk);
    if (op[7:1] == 7'h01) begin
      host_u.xbyte(a[15:8], junk);
      host_u.xbyte(a[7:0], junk);
    end
    host_u.xbyte(w0, r0);
    host_u.xbyte(w1, r1);
    host_u.frame_end();
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    logic [7:0]  r0, r1, ex;
    logic [12:0] a2;
    repeat (3) @(posedge mclk);
    check({6'h00, so_oe, standby}, 8'h01);
    #2 rst = 1'b0;
    repeat (4) @(posedge mclk);
    #2;
    $display("reset test done");
    foreach (rows[k]) begin
      access(`SSP_STATUS_WRITE_CMD, 16'h0000, rows[k].sts, 8'h00, r0, r1);
      access(`SSP_STATUS_READ_CMD, 16'h0000, 8'hFF, 8'hFF, r0, r1);
      ex = (rows[k].sts & 8'hC1) | 8'h02;
      check(r0, ex);
      check(r1, ex);
      access(`SSP_CMD_WRITE, rows[k].addr, rows[k].d0, rows[k].d1, r0, r1);
      for (int i = 0; i < 60 && standby !== 1'b1; i++) begin
        @(posedge mclk);
        #2;
      end
      check({7'h00, standby}, 8'h01);
      check({7'h00, so_oe}, 8'h00);
      a2 = next_addr(rows[k].sts[7:6], rows[k].addr[12:0]);
      access(`SSP_CMD_READ, {3'b000, rows[k].addr[12:0]}, 8'hFF, 8'hFF, r0, r1);
      check(r0, (a2 == rows[k].addr[12:0]) ? rows[k].d1 : rows[k].d0);
      check(r1, rows[k].d1);
      access(`SSP_CMD_READ, {3'b111, a2}, 8'hFF, 8'hFF, r0, r1);
      check(r0, rows[k].d1);
      $display("row %0d done", k);
    end
    host_u.frame_start();
    host_u.xbyte(`SSP_CMD_READ, r0);
    host_u.xbyte(8'h00, r0);
    host_u.xbyte(8'h05, r0);
    for (int i = 7; i >= 5; i--) host_u.xbit(1'b0, r1[i]);
    host_u.pause_on();
    check({7'h00, so_oe}, 8'h00);
    host_u.pause_off();
    for (int i = 4; i >= 0; i--) host_u.xbit(1'b0, r1[i]);
    host_u.frame_end();
    check(r1, 8'h3C);
    $display("pause test done");
    oe_hits = 0;
    host_u.frame_start();
    host_u.xbyte(8'hC3, r0);
    host_u.xbyte(`SSP_CMD_READ, r0);
    host_u.xbyte(8'h00, r0);
    host_u.xbyte(8'h05, r0);
    host_u.xbyte(8'hFF, r0);
    host_u.frame_end();
    check({7'h00, oe_hits != 0}, 8'h00);
    access(`SSP_STATUS_READ_CMD, 16'h0000, 8'hFF, 8'hFF, r0, r1);
    check(r0, 8'hC3);
    $display("unknown code test done");
    report_and_stop();
  end
endmodule
